// ==== verilog/zdcf_pkg.sv ====
// Package for the zero-delay clock fan-out mode and output-control logic.
// Assumes a single 50 MHz system clock samples every pin of the block.
package zdcf_pkg;
  localparam int ZDCF_CLK_HZ = 50_000_000;
  // Slowest reference that still counts as present, in hertz
  localparam int ZDCF_MIN_REF_HZ = 2_000_000;
  // Longest reference period in system cycles, rounded down
  localparam int ZDCF_SLOW_CYC = ZDCF_CLK_HZ / ZDCF_MIN_REF_HZ;
  // Reference edges to wait for before the loop counts as locked
  localparam int ZDCF_LOCK_EDGES = 64;
  // Largest reference period drift, in system cycles, not yet seen as a reference change
  localparam int ZDCF_DRIFT_CYC = 2;
  localparam int ZDCF_BANK_W = 4;
  localparam int ZDCF_CNT_W = 16;

  typedef enum logic [3:0] {
    ZDCF_OFF    = 4'h1,
    ZDCF_LOOP_A = 4'h2,
    ZDCF_BYPASS = 4'h4,
    ZDCF_LOOP_B = 4'h8
  } zdcf_mode_e;

  typedef struct packed {
    logic [ZDCF_BANK_W-1:0] bank_a;
    logic [ZDCF_BANK_W-1:0] bank_b;
  } zdcf_out_s;

  typedef struct packed {
    logic [ZDCF_BANK_W-1:0] bank_a;
    logic [ZDCF_BANK_W-1:0] bank_b;
  } zdcf_oe_s;
endpackage : zdcf_pkg

// ==== verilog/zdcf_core.sv ====
// Mode decode, reference monitor, lock timer and output regeneration.
// Assumes pins are asynchronous to ref_clk; the output wire level is resolved outside.
//
// Contract
// - Select pins decode off, bank A, both banks
// - Upper-only select bypasses reference to both banks
// - Loop modes drive low below 2 MHz
// - Missing reference holds all outputs low
// - Outputs held low while loop locks after changes
// - Loop outputs regenerated at 50% duty
// - Eight outputs in two banks; none in off mode, bank A alone in bank-A mode, both banks in bypass and loop-B modes
// - Feedback only observed; loop output restarts high on each reference edge
`timescale 1ns/1ps
`default_nettype none
module zdcf_core #(
  parameter int LOCK_EDGES = zdcf_pkg::ZDCF_LOCK_EDGES,
  parameter int SLOW_CYC = zdcf_pkg::ZDCF_SLOW_CYC
) (
  // Clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Pins
  input wire logic reference_clock_in,
  input wire logic loop_feedback_in,
  input wire logic select_lower,
  input wire logic select_upper,
  // Outputs
  output zdcf_pkg::zdcf_out_s clk_out,
  output zdcf_pkg::zdcf_oe_s clk_oe,
  output logic ref_present,
  output logic loop_locked
);
  import zdcf_pkg::*;

  // Two flops per pin; the third reference flop only feeds the edge detector
  logic [2:0] ref_sync_q;
  logic [1:0] fb_sync_q;
  logic [1:0] sl_sync_q;
  logic [1:0] su_sync_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ref_sync_q <= 3'h0;
      fb_sync_q <= 2'h0;
      sl_sync_q <= 2'h0;
      su_sync_q <= 2'h0;
    end else if (clk_en) begin
      ref_sync_q <= {ref_sync_q[1:0], reference_clock_in};
      fb_sync_q <= {fb_sync_q[0], loop_feedback_in};
      sl_sync_q <= {sl_sync_q[0], select_lower};
      su_sync_q <= {su_sync_q[0], select_upper};
    end
  end
  logic ref_lvl;
  logic ref_rise;
  assign ref_lvl = ref_sync_q[1];
  assign ref_rise = ref_sync_q[1] & ~ref_sync_q[2];

  zdcf_mode_e mode_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q <= ZDCF_OFF;
    end else if (clk_en) begin
      unique case ({su_sync_q[1], sl_sync_q[1]})
        2'b00: mode_q <= ZDCF_OFF;
        2'b01: mode_q <= ZDCF_LOOP_A;
        2'b10: mode_q <= ZDCF_BYPASS;
        2'b11: mode_q <= ZDCF_LOOP_B;
      endcase
    end
  end
  logic loop_mode;
  assign loop_mode = (mode_q == ZDCF_LOOP_A) || (mode_q == ZDCF_LOOP_B);

  // Period counter saturates, so a stopped reference reads as slow forever
  logic [ZDCF_CNT_W-1:0] gap_q;
  logic [ZDCF_CNT_W-1:0] period_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gap_q <= '0;
      period_q <= '0;
      ref_present <= 1'b0;
    end else if (clk_en) begin
      if (ref_rise) begin
        gap_q <= '0;
        period_q <= gap_q + 1'b1;
        ref_present <= 1'b1;
      end else begin
        if (gap_q != '1) begin
          gap_q <= gap_q + 1'b1;
        end
        if (gap_q >= ZDCF_CNT_W'(SLOW_CYC)) begin
          ref_present <= 1'b0;
        end
      end
    end
  end

  function automatic logic drifted(input logic [ZDCF_CNT_W-1:0] a,
                                   input logic [ZDCF_CNT_W-1:0] b);
    drifted = (a > b) ? (a - b > ZDCF_CNT_W'(ZDCF_DRIFT_CYC))
                      : (b - a > ZDCF_CNT_W'(ZDCF_DRIFT_CYC));
  endfunction : drifted

  // Lock restarts on reset, off/bypass, reference loss or period change
  logic [ZDCF_CNT_W-1:0] lock_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_cnt_q <= '0;
      loop_locked <= 1'b0;
    end else if (clk_en) begin
      if (!loop_mode || !ref_present ||
          (ref_rise && drifted(gap_q + 1'b1, period_q))) begin
        lock_cnt_q <= '0;
        loop_locked <= 1'b0;
      end else if (ref_rise && !loop_locked) begin
        lock_cnt_q <= lock_cnt_q + 1'b1;
        loop_locked <= (lock_cnt_q + 1'b1 >= ZDCF_CNT_W'(LOCK_EDGES));
      end
    end
  end

  // Regenerated clock: toggles at half period so duty stays 50% whatever the input
  logic [ZDCF_CNT_W-1:0] half_q;
  logic [ZDCF_CNT_W-1:0] phase_q;
  logic regen_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      half_q <= '0;
      phase_q <= '0;
      regen_q <= 1'b0;
    end else if (clk_en) begin
      if (ref_rise) begin
        half_q <= period_q >> 1;
        phase_q <= '0;
        regen_q <= 1'b1;
      end else if (phase_q + 1'b1 >= half_q && half_q != '0) begin
        phase_q <= '0;
        regen_q <= ~regen_q;
      end else begin
        phase_q <= phase_q + 1'b1;
      end
    end
  end
  // Feedback only observed; the analog loop that would trim phase is not modelled
  logic fb_unused;
  assign fb_unused = fb_sync_q[1];

  logic src;
  always_comb begin
    src = 1'b0;
    if (ref_present) begin
      if (mode_q == ZDCF_BYPASS) begin
        src = ref_lvl;
      end else if (loop_mode && loop_locked) begin
        src = regen_q;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_out <= '0;
      clk_oe <= '0;
    end else if (clk_en) begin
      clk_out.bank_a <= {ZDCF_BANK_W{src}};
      clk_out.bank_b <= {ZDCF_BANK_W{src & (mode_q != ZDCF_LOOP_A)}};
      clk_oe.bank_a <= {ZDCF_BANK_W{mode_q != ZDCF_OFF}};
      clk_oe.bank_b <= {ZDCF_BANK_W{(mode_q == ZDCF_BYPASS) || (mode_q == ZDCF_LOOP_B)}};
    end
  end

  off_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && mode_q == ZDCF_OFF |=> clk_oe == '0)
    else $error("Outputs enabled in off mode");
  bank_b_loop_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && mode_q == ZDCF_LOOP_A |=> clk_oe.bank_b == '0 && clk_oe.bank_a == '1)
    else $error("Bank enables wrong in single-bank loop mode");
  bypass_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && mode_q == ZDCF_BYPASS && ref_present |=> clk_out.bank_b[0] == $past(ref_lvl))
    else $error("Bypass output does not follow reference");
  absent_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !ref_present |=> clk_out == '0)
    else $error("Output high without reference");
  unlocked_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && loop_mode && !loop_locked |=> clk_out == '0)
    else $error("Loop output before lock");
  slow_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !ref_rise && gap_q >= ZDCF_CNT_W'(SLOW_CYC) |=> !ref_present)
    else $error("Slow reference not detected");
  lock_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(loop_locked) |-> lock_cnt_q >= ZDCF_CNT_W'(LOCK_EDGES))
    else $error("Lock declared early");
  bank_same_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_out.bank_a == {ZDCF_BANK_W{clk_out.bank_a[0]}})
    else $error("Bank outputs differ");
  banks_match_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_oe.bank_b == '1 |-> clk_out.bank_b == clk_out.bank_a)
    else $error("Enabled banks differ");
  lone_bank_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && mode_q == ZDCF_LOOP_A |=> clk_out.bank_b == '0)
    else $error("Disabled bank driven in single-bank mode");
  loop_shut_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !loop_mode |=> !loop_locked)
    else $error("Loop locked while shut down");
  edge_present_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && ref_rise |=> ref_present)
    else $error("Reference edge not reported");
  lock_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && loop_mode && loop_locked && ref_present && !ref_rise |=> loop_locked)
    else $error("Lock lost without cause");
  regen_align_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && ref_rise |=> regen_q)
    else $error("Regenerated clock not aligned to reference edge");
  // A stalled enable must hold the pins steady, or loads see a runt pulse
  freeze_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !clk_en |=> $stable(clk_out) && $stable(clk_oe) && $stable(loop_locked))
    else $error("Outputs moved while the clock enable was low");
endmodule : zdcf_core
`default_nettype wire

// ==== tb/zdcf_ref_src.sv ====
// Board model: reference clock source and the feedback trace.
// Assumes the bench sets run and the half period in ns.
`timescale 1ns/1ps
`default_nettype none
module zdcf_ref_src (
  // Bench control
  input wire logic run,
  input wire logic [15:0] half_ns,
  // Board side
  input wire logic tap_out,
  input wire logic tap_oe,
  output logic ref_out,
  output logic fb_out
);
  // A stopped source rests low, as a missing signal does
  initial ref_out = 1'b0;
  always begin
    if (run) begin
      #(half_ns) ref_out = ~ref_out;
    end else begin
      ref_out = 1'b0;
      #20;
    end
  end
  // Tap carries no other load; undriven trace shows a moving level
  assign fb_out = tap_oe ? tap_out : ~ref_out;
endmodule : zdcf_ref_src
`default_nettype wire

// ==== tb/test_zero_delay_clock_fanout_modes.sv ====
// Bench for the fan-out mode and output logic.
// Assumes a small lock count keeps the run short.
`timescale 1ns/1ps
`default_nettype none
module test_zero_delay_clock_fanout_modes;
  import zdcf_pkg::*;
  localparam int LOCK_N = 4;
  logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, sel_lo = 1'b0, sel_up = 1'b0;
  logic run = 1'b0, ref_in, fb, ref_present, loop_locked;
  logic [15:0] half_ns = 16'd150;
  zdcf_out_s clk_out;
  zdcf_oe_s clk_oe;
  int fails = 0, checks_done = 0;
  always #10 ref_clk = ~ref_clk;
  zdcf_core #(.LOCK_EDGES(LOCK_N), .SLOW_CYC(ZDCF_SLOW_CYC)) uut (.ref_clk(ref_clk),
    .rst(rst), .clk_en(clk_en), .reference_clock_in(ref_in), .loop_feedback_in(fb),
    .select_lower(sel_lo), .select_upper(sel_up), .clk_out(clk_out), .clk_oe(clk_oe),
    .ref_present(ref_present), .loop_locked(loop_locked));
  zdcf_ref_src src (.run(run), .half_ns(half_ns), .tap_out(clk_out.bank_a[0]),
    .tap_oe(clk_oe.bank_a[0]), .ref_out(ref_in), .fb_out(fb));
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_oe(input logic lo, input logic up);
    if (!up) return lo ? 8'hF0 : 8'h00;
    return 8'hFF;
  endfunction : exp_oe
  task automatic mode(input logic lo, input logic up);
    @(posedge ref_clk);
    sel_lo <= lo;
    sel_up <= up;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : mode
  // Bounded wait for the lock flag; returns cycles spent
  task automatic wait_for(input logic want, output int k);
    k = 0;
    while (loop_locked !== want) begin
      @(posedge ref_clk);
      #1;
      k++;
      if (k > 3000) begin
        fails++;
        give_verdict();
      end
    end
  endtask : wait_for
  // Counts high cycles of one output; flags any bank output that differs
  // Slip is output rises minus reference rises over the window
  task automatic watch(input int n, output int hi, output logic split, output int slip);
    logic o_prev, r_prev;
    hi = 0;
    split = 1'b0;
    slip = 0;
    o_prev = clk_out.bank_a[0];
    r_prev = ref_in;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      hi += int'(clk_out.bank_a[0]);
      if (clk_out !== {8{clk_out.bank_a[0]}}) split = 1'b1;
      slip += int'(clk_out.bank_a[0] & ~o_prev) - int'(ref_in & ~r_prev);
      o_prev = clk_out.bank_a[0];
      r_prev = ref_in;
    end
  endtask : watch
  initial begin
    int hi, t, slip, moved;
    logic split;
    logic [7:0] frozen;
    void'($urandom(32'h047E));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(clk_oe, 8'h00);
    half_ns <= 16'($urandom_range(170, 120));
    run <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      t = (i < 4) ? i : int'($urandom_range(3, 0));
      mode(t[0], t[1]);
      chk(clk_oe, exp_oe(t[0], t[1]));
      chk(clk_out & ~clk_oe, 8'h00);
    end
    mode(1'b1, 1'b1);
    wait_for(1'b1, t);
    half_ns <= half_ns + 16'd60;
    wait_for(1'b0, t);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(clk_out, 8'h00);
    wait_for(1'b1, t);
    chk(8'(t >= (LOCK_N - 1) * (half_ns / 10)), 8'h01);
    watch(400, hi, split, slip);
    chk(8'(hi > 175 && hi < 225), 8'h01);
    chk(8'(split), 8'h00);
    chk(8'(slip >= -1 && slip <= 1), 8'h01);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    #1;
    frozen = clk_out;
    moved = 0;
    repeat (30) begin
      @(posedge ref_clk);
      #1;
      moved += int'(clk_out !== frozen || loop_locked !== 1'b1);
    end
    @(posedge ref_clk);
    clk_en <= 1'b1;
    chk(8'(moved), 8'h00);
    half_ns <= 16'd400;
    repeat (100) @(posedge ref_clk);
    watch(200, hi, split, slip);
    chk(8'(hi), 8'h00);
    chk(8'(loop_locked), 8'h00);
    half_ns <= 16'd150;
    mode(1'b0, 1'b1);
    repeat (20) @(posedge ref_clk);
    watch(300, hi, split, slip);
    chk(8'(hi > 130 && hi < 170), 8'h01);
    chk(8'(split), 8'h00);
    chk(8'(loop_locked), 8'h00);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(clk_oe | clk_out, 8'h00);
    chk(8'({ref_present, loop_locked}), 8'h00);
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (25) @(posedge ref_clk);
    #1;
    chk(clk_oe, 8'hFF);
    chk(8'(ref_present), 8'h01);
    run <= 1'b0;
    repeat (60) @(posedge ref_clk);
    watch(100, hi, split, slip);
    chk(8'(hi), 8'h00);
    chk(8'(ref_present), 8'h00);
    give_verdict();
  end
endmodule : test_zero_delay_clock_fanout_modes
`default_nettype wire
